/* File: tqt_defs.svh */
`ifndef TQT_DEFS_SVH
`define TQT_DEFS_SVH

// Register indices; the byte address on the bus is four times the index.
`define TQT_IDX_T0_DAT_LO 10'h068
`define TQT_IDX_T0_DAT_HI 10'h069
`define TQT_IDX_T1_DAT_LO 10'h06a
`define TQT_IDX_T1_DAT_HI 10'h06b
`define TQT_IDX_T0_CNT_LO 10'h06c
`define TQT_IDX_T0_CNT_HI 10'h06d
`define TQT_IDX_T1_CNT_LO 10'h06e
`define TQT_IDX_T1_CNT_HI 10'h06f
`define TQT_IDX_T0_MODE 10'h070
`define TQT_IDX_T0_CLK 10'h071
`define TQT_IDX_T1_MODE 10'h072
`define TQT_IDX_T1_CLK 10'h073
`define TQT_IDX_T2_DAT_LO 10'h076
`define TQT_IDX_T2_DAT_HI 10'h077
`define TQT_IDX_T3_DAT_LO 10'h078
`define TQT_IDX_T3_DAT_HI 10'h079
`define TQT_IDX_T2_CNT_LO 10'h07a
`define TQT_IDX_T2_CNT_HI 10'h07b
`define TQT_IDX_T3_CNT_LO 10'h07c
`define TQT_IDX_T3_CNT_HI 10'h07d

// Field positions inside the mode registers.
`define TQT_T0_RUN_BIT 0
`define TQT_T0_CAP_BIT 1
`define TQT_T0_FMEAS_BIT 2
`define TQT_T1_RUN_BIT 0
`define TQT_T1_CAP_BIT 1

// Reset values.
`define TQT_T0_MODE_RESET 3'h0
`define TQT_T1_MODE_RESET 2'h0
`define TQT_CLK_RESET 2'h0
`define TQT_CNT_RESET 8'h00

// Width of one software-visible register.
`define TQT_NIB_W 4

`endif

/* File: tqt_pkg.sv */
package tqt_pkg;

  // Clock source codes shared by both clock-select fields.
  typedef enum logic [1:0] {
    TQT_CLK_LOW = 2'h0,
    TQT_CLK_HIGH = 2'h1,
    TQT_CLK_EXT = 2'h2,
    TQT_CLK_CHAIN = 2'h3
  } tqt_clk_sel_t;

  // Effective run, capture and reload controls of one channel.
  typedef struct packed {
    logic run;
    logic capture_sel;
    logic reload;
  } tqt_chan_ctl_t;

  // Per-nibble write strobes.
  typedef struct packed {
    logic hi;
    logic lo;
  } tqt_nib_we_t;

endpackage : tqt_pkg

/* File: tqt_chan.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tqt_defs.svh"

module tqt_chan #(
  parameter int WIDTH = 8
) (
  input wire logic clk_i, // System clock.
  input wire logic rst_n_i, // Synchronous reset, active low.
  input wire logic tick_i, // One-cycle count pulse from the selected source.
  input wire tqt_pkg::tqt_chan_ctl_t ctl_i, // Effective mode controls.
  input wire logic cap_evt_i, // One-cycle capture event.
  input wire tqt_pkg::tqt_nib_we_t cnt_we_i, // Counter nibble write strobes.
  input wire tqt_pkg::tqt_nib_we_t dat_we_i, // Data nibble write strobes.
  input wire logic [3:0] wdata_i, // Nibble written by software.
  output logic [WIDTH-1:0] count_o, // Counter value.
  output logic [WIDTH-1:0] data_o, // Reload or capture value.
  output logic ovf_o // One-cycle overflow pulse.
);
  import tqt_pkg::*;

  // The nibble layout only serves a counter of exactly two nibbles.
  if (WIDTH != 2 * `TQT_NIB_W) begin : g_bad_width
    $error("tqt_chan serves an 8-bit counter only");
  end

  logic [WIDTH-1:0] count_r, count_nxt; // Counter state.
  logic [WIDTH-1:0] data_r, data_nxt; // Data register state.
  logic step; // Counter advances this cycle.
  logic at_top; // Counter sits at its highest value.

  assign step = tick_i & ctl_i.run;
  assign at_top = (count_r == {WIDTH{1'b1}});
  assign ovf_o = step & at_top;

  // Counter next value; software writes win over counting.
  always_comb begin
    count_nxt = count_r;
    if (step) begin
      count_nxt = (at_top && ctl_i.reload) ? data_r : count_r + 1'b1;
    end
    if (cnt_we_i.lo) begin
      count_nxt[3:0] = wdata_i;
    end
    if (cnt_we_i.hi) begin
      count_nxt[7:4] = wdata_i;
    end
  end

  // Data next value; a capture is kept over a plain data write.
  always_comb begin
    data_nxt = data_r;
    if (dat_we_i.lo) begin
      data_nxt[3:0] = wdata_i;
    end
    if (dat_we_i.hi) begin
      data_nxt[7:4] = wdata_i;
    end
    if (cap_evt_i && ctl_i.capture_sel && ctl_i.run) begin
      data_nxt = count_r;
    end
    if (cnt_we_i.lo) begin
      data_nxt[3:0] = wdata_i;
    end
    if (cnt_we_i.hi) begin
      data_nxt[7:4] = wdata_i;
    end
  end

  // State update with synchronous clear.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      count_r <= `TQT_CNT_RESET;
      data_r <= `TQT_CNT_RESET;
    end else begin
      count_r <= count_nxt;
      data_r <= data_nxt;
    end
  end

  assign count_o = count_r;
  assign data_o = data_r;

  // A stopped channel never moves on its own.
  chan_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!ctl_i.run && cnt_we_i == 2'b00) |=> count_r == $past(count_r))
    else $error("stopped counter changed");

endmodule : tqt_chan

`default_nettype wire

/* File: tqt_timer.sv */
// Function
// - Timers count as 8-bit binary counters.
// - Reset clears all counters and controls.
// - Counter write also loads data nibble.
// - Data write leaves counter untouched.
// - Timer 0 mode: measure, capture, run bits.
// - Timer 0 clock: low, high, external.
// - Timer 1 mode: capture and run bits.
// - Timer 0 external clock from port pin.
// - Counter nibbles readable and writable.
// - Auto-reload loads data into counter.
// - Capture stores counter into data.
// - Timer 1 may use high-speed clock.
`timescale 1ns/1ps
`default_nettype none
`include "tqt_defs.svh"

module tqt_timer (
  input wire logic CLK_I, // System clock, 25 MHz.
  input wire logic RST_N_I, // Synchronous reset, active low.
  input wire logic PSEL_I, // APB select.
  input wire logic PENABLE_I, // APB access phase.
  input wire logic PWRITE_I, // APB direction, high for write.
  input wire logic [11:0] PADDR_I, // APB byte address.
  input wire logic [31:0] PWDATA_I, // APB write data.
  input wire logic [3:0] PSTRB_I, // APB byte strobes.
  output logic [31:0] PRDATA_O, // APB read data.
  output logic PREADY_O, // APB ready, always high.
  output logic PSLVERR_O, // APB error on unmapped address.
  input wire logic LOW_SPEED_TIMEBASE_CLOCK_I, // Low-speed timebase, sampled.
  input wire logic HIGH_SPEED_CLOCK_I, // High-speed clock, sampled.
  input wire logic PORT_B_LINE_TWO_I, // Shared pin, timer 0 external clock.
  input wire logic T1_EXT_CLOCK_I, // Timer 1 external clock pin.
  input wire logic T0_CAPTURE_I, // Timer 0 capture pin.
  input wire logic T1_CAPTURE_I // Timer 1 capture pin.
);
  import tqt_pkg::*;

  localparam int NCH = 4; // Number of timer channels.

  // Register indices per channel, in channel order.
  localparam logic [9:0] CNT_LO_IDX [NCH] = '{`TQT_IDX_T0_CNT_LO, `TQT_IDX_T1_CNT_LO,
                                              `TQT_IDX_T2_CNT_LO, `TQT_IDX_T3_CNT_LO};
  localparam logic [9:0] CNT_HI_IDX [NCH] = '{`TQT_IDX_T0_CNT_HI, `TQT_IDX_T1_CNT_HI,
                                              `TQT_IDX_T2_CNT_HI, `TQT_IDX_T3_CNT_HI};
  localparam logic [9:0] DAT_LO_IDX [NCH] = '{`TQT_IDX_T0_DAT_LO, `TQT_IDX_T1_DAT_LO,
                                              `TQT_IDX_T2_DAT_LO, `TQT_IDX_T3_DAT_LO};
  localparam logic [9:0] DAT_HI_IDX [NCH] = '{`TQT_IDX_T0_DAT_HI, `TQT_IDX_T1_DAT_HI,
                                              `TQT_IDX_T2_DAT_HI, `TQT_IDX_T3_DAT_HI};

  // Address match for one word-aligned register index.
  function automatic logic hit(input logic [11:0] addr, input logic [9:0] idx);
    hit = (addr[11:2] == idx) && (addr[1:0] == 2'h0);
  endfunction : hit

  // Bus phase decode.
  logic setup_ph; // Setup cycle of a transfer.
  logic wr_en; // Write takes effect on this edge.
  logic [3:0] wnib; // Written nibble.
  logic mapped; // Address hits any register.
  logic [3:0] rd_nib; // Nibble selected for reading.
  logic [3:0] prdata_r; // Read data captured in setup.

  assign setup_ph = PSEL_I & ~PENABLE_I;
  // Only the low byte lane carries register data, so it gates the write.
  assign wr_en = PSEL_I & PENABLE_I & PWRITE_I & PSTRB_I[0];
  // Every register is one nibble wide, so upper data bits are ignored.
  assign wnib = PWDATA_I[3:0];

  // Control registers.
  logic [2:0] t0_mode_r, t0_mode_nxt; // Timer 0 mode field.
  logic [1:0] t0_clk_r, t0_clk_nxt; // Timer 0 clock select.
  logic [1:0] t1_mode_r, t1_mode_nxt; // Timer 1 mode field.
  logic [1:0] t1_clk_r, t1_clk_nxt; // Timer 1 clock select.

  // Control register writes decoded by address.
  // A write outside the access phase or without the low strobe changes nothing.
  assign t0_mode_nxt = (wr_en && hit(PADDR_I, `TQT_IDX_T0_MODE)) ? wnib[2:0] : t0_mode_r;
  assign t0_clk_nxt = (wr_en && hit(PADDR_I, `TQT_IDX_T0_CLK)) ? wnib[1:0] : t0_clk_r;
  assign t1_mode_nxt = (wr_en && hit(PADDR_I, `TQT_IDX_T1_MODE)) ? wnib[1:0] : t1_mode_r;
  assign t1_clk_nxt = (wr_en && hit(PADDR_I, `TQT_IDX_T1_CLK)) ? wnib[1:0] : t1_clk_r;

  // Control register update.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      t0_mode_r <= `TQT_T0_MODE_RESET;
      t0_clk_r <= `TQT_CLK_RESET;
      t1_mode_r <= `TQT_T1_MODE_RESET;
      t1_clk_r <= `TQT_CLK_RESET;
    end else begin
      t0_mode_r <= t0_mode_nxt;
      t0_clk_r <= t0_clk_nxt;
      t1_mode_r <= t1_mode_nxt;
      t1_clk_r <= t1_clk_nxt;
    end
  end

  // Previous levels of the sampled clock and capture pins.
  logic low_prev_r; // Timebase level last cycle.
  logic high_prev_r; // High-speed level last cycle.
  logic ext0_prev_r; // Port pin level last cycle.
  logic t1x_prev_r; // Timer 1 external level last cycle.
  logic cap0_prev_r; // Timer 0 capture pin last cycle.
  logic cap1_prev_r; // Timer 1 capture pin last cycle.

  // Edge history; inputs are already synchronous, so no synchroniser is needed.
  // A pin already high as reset ends gives one edge, a known limitation.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      low_prev_r <= 1'b0;
      high_prev_r <= 1'b0;
      ext0_prev_r <= 1'b0;
      t1x_prev_r <= 1'b0;
      cap0_prev_r <= 1'b0;
      cap1_prev_r <= 1'b0;
    end else begin
      low_prev_r <= LOW_SPEED_TIMEBASE_CLOCK_I;
      high_prev_r <= HIGH_SPEED_CLOCK_I;
      ext0_prev_r <= PORT_B_LINE_TWO_I;
      t1x_prev_r <= T1_EXT_CLOCK_I;
      cap0_prev_r <= T0_CAPTURE_I;
      cap1_prev_r <= T1_CAPTURE_I;
    end
  end

  // Rising edges count; a capture fires on any change of the pin level.
  logic low_rise, high_rise, timer_external_clock_in_rise, t1x_rise;
  logic [NCH-1:0] cap_evt; // Capture events per channel.
  assign low_rise = LOW_SPEED_TIMEBASE_CLOCK_I & ~low_prev_r;
  assign high_rise = HIGH_SPEED_CLOCK_I & ~high_prev_r;
  assign timer_external_clock_in_rise = PORT_B_LINE_TWO_I & ~ext0_prev_r;
  assign t1x_rise = T1_EXT_CLOCK_I & ~t1x_prev_r;
  // Timers 2 and 3 have no capture pins, so their events stay low.
  assign cap_evt = {2'b00, T1_CAPTURE_I ^ cap1_prev_r, T0_CAPTURE_I ^ cap0_prev_r};

  // Timer 0 mode decode.
  logic t0_freq_measure_select, t0_capture_select, t0_run; // Mode field bits.
  logic t0_code_ok; // Mode code is one of the defined five.
  tqt_chan_ctl_t [NCH-1:0] ctl; // Effective controls per channel.
  logic [NCH-1:0] tick; // Count pulses per channel.
  logic [NCH-1:0] ovf; // Overflow pulses per channel.

  assign t0_freq_measure_select = t0_mode_r[`TQT_T0_FMEAS_BIT];
  assign t0_capture_select = t0_mode_r[`TQT_T0_CAP_BIT];
  assign t0_run = t0_mode_r[`TQT_T0_RUN_BIT];
  assign t0_code_ok = ~t0_freq_measure_select | (~t0_capture_select & ~t0_run);
  // Frequency measurement counts the selected source without a stop code of its own.
  assign ctl[0].run = t0_code_ok & (t0_run | t0_freq_measure_select);
  assign ctl[0].capture_sel = t0_capture_select & ~t0_freq_measure_select;
  assign ctl[0].reload = ~t0_capture_select;

  assign tick[0] = (t0_clk_r == TQT_CLK_LOW) ? low_rise :
                   (t0_clk_r == TQT_CLK_HIGH) ? high_rise :
                   (t0_clk_r == TQT_CLK_EXT) ? timer_external_clock_in_rise : 1'b0;

  // Timer 1 mode decode; code 00 with the overflow clock is the chained mode.
  logic t1_capture_select, t1_run, t1_chained; // Mode field bits and chain state.
  assign t1_capture_select = t1_mode_r[`TQT_T1_CAP_BIT];
  assign t1_run = t1_mode_r[`TQT_T1_RUN_BIT];
  assign t1_chained = (t1_clk_r == TQT_CLK_CHAIN) && (t1_mode_r == 2'h0);
  // Code 00 doubles as the chained mode, so chaining runs without the run bit.
  assign ctl[1].run = t1_run | t1_chained;
  assign ctl[1].capture_sel = t1_capture_select;
  assign ctl[1].reload = ~t1_capture_select;

  assign tick[1] = (t1_clk_r == TQT_CLK_LOW) ? low_rise :
                   (t1_clk_r == TQT_CLK_HIGH) ? high_rise :
                   (t1_clk_r == TQT_CLK_EXT) ? t1x_rise : ovf[0];

  // Timers 2 and 3 have no controls in this block and stay stopped.
  assign ctl[3:2] = '0;
  assign tick[3:2] = 2'b00;

  // Channel counters and their software strobes.
  logic [7:0] count [NCH]; // Counter values.
  logic [7:0] data [NCH]; // Data register values.
  tqt_nib_we_t [NCH-1:0] cnt_we; // Counter nibble writes.
  tqt_nib_we_t [NCH-1:0] dat_we; // Data nibble writes.
  logic [NCH-1:0] ch_hit; // Any register of the channel addressed.
  logic [3:0] ch_rd [NCH]; // Read nibble offered by each channel.

  for (genvar i = 0; i < NCH; i++) begin : g_chan
    assign cnt_we[i].lo = wr_en & hit(PADDR_I, CNT_LO_IDX[i]);
    assign cnt_we[i].hi = wr_en & hit(PADDR_I, CNT_HI_IDX[i]);
    assign dat_we[i].lo = wr_en & hit(PADDR_I, DAT_LO_IDX[i]);
    assign dat_we[i].hi = wr_en & hit(PADDR_I, DAT_HI_IDX[i]);
    assign ch_hit[i] = hit(PADDR_I, CNT_LO_IDX[i]) | hit(PADDR_I, CNT_HI_IDX[i]) |
                       hit(PADDR_I, DAT_LO_IDX[i]) | hit(PADDR_I, DAT_HI_IDX[i]);
    assign ch_rd[i] = hit(PADDR_I, CNT_LO_IDX[i]) ? count[i][3:0] :
                      hit(PADDR_I, CNT_HI_IDX[i]) ? count[i][7:4] :
                      hit(PADDR_I, DAT_LO_IDX[i]) ? data[i][3:0] :
                      hit(PADDR_I, DAT_HI_IDX[i]) ? data[i][7:4] : 4'h0;

    // One counter and data register pair per timer.
    tqt_chan #(
      .WIDTH(8)
    ) u_chan (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .tick_i(tick[i]),
      .ctl_i(ctl[i]),
      .cap_evt_i(cap_evt[i]),
      .cnt_we_i(cnt_we[i]),
      .dat_we_i(dat_we[i]),
      .wdata_i(wnib),
      .count_o(count[i]),
      .data_o(data[i]),
      .ovf_o(ovf[i])
    );
  end

  // Read selection; channel nibbles are zero unless addressed, so they OR together.
  logic ctl_hit; // A control register is addressed.
  logic [3:0] ctl_rd; // Control register read nibble.
  assign ctl_hit = hit(PADDR_I, `TQT_IDX_T0_MODE) | hit(PADDR_I, `TQT_IDX_T0_CLK) |
                   hit(PADDR_I, `TQT_IDX_T1_MODE) | hit(PADDR_I, `TQT_IDX_T1_CLK);
  assign ctl_rd = hit(PADDR_I, `TQT_IDX_T0_MODE) ? {1'b0, t0_mode_r} :
                  hit(PADDR_I, `TQT_IDX_T0_CLK) ? {2'b00, t0_clk_r} :
                  hit(PADDR_I, `TQT_IDX_T1_MODE) ? {2'b00, t1_mode_r} :
                  hit(PADDR_I, `TQT_IDX_T1_CLK) ? {2'b00, t1_clk_r} : 4'h0;
  assign rd_nib = ctl_rd | ch_rd[0] | ch_rd[1] | ch_rd[2] | ch_rd[3];
  // Any hole in the map, status registers included, counts as unmapped.
  assign mapped = ctl_hit | (|ch_hit);

  // Read data is taken in the setup cycle so that the access phase needs no wait.
  // The value is therefore the one of the setup cycle, one edge before completion.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      prdata_r <= 4'h0;
    end else if (setup_ph) begin
      prdata_r <= mapped ? rd_nib : 4'h0;
    end
  end

  // Unused upper bits read zero.
  assign PRDATA_O = {28'h0000000, prdata_r};
  // The slave never stalls, so each access phase is its last cycle.
  assign PREADY_O = 1'b1;
  // An unmapped address answers with an error and writes nothing.
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~mapped;

  // A write of a counter nibble in the access phase.
  sequence t0_lo_wr_s;
    wr_en && hit(PADDR_I, `TQT_IDX_T0_CNT_LO);
  endsequence

  // Reset leaves timer 0 and 3 counters, timer 1 data, timer 0 mode and timer 1 clock select at zero.
  reset_zero_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    $rose(RST_N_I) |-> (count[0] == 8'h00 && data[1] == 8'h00 && t0_mode_r == 3'h0 &&
                        t1_clk_r == 2'h0 && count[3] == 8'h00))
    else $error("state not cleared by reset");

  cnt_mirror_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    t0_lo_wr_s |=> (count[0][3:0] == $past(wnib) && data[0][3:0] == $past(wnib)))
    else $error("counter write not mirrored into data");

  data_only_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (wr_en && hit(PADDR_I, `TQT_IDX_T0_DAT_HI) && !tick[0] && !cap_evt[0]) |=>
      (count[0] == $past(count[0]) && data[0][7:4] == $past(wnib)))
    else $error("data write disturbed the counter");

  count_step_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (tick[0] && ctl[0].run && count[0] != 8'hff && cnt_we[0] == 2'b00) |=>
      count[0] == $past(count[0]) + 8'h01)
    else $error("counter did not step by one");

  reload_val_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (ovf[0] && ctl[0].reload && cnt_we[0] == 2'b00) |=> count[0] == $past(data[0]))
    else $error("reload value not loaded");

  capture_val_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (cap_evt[1] && ctl[1].capture_sel && ctl[1].run && cnt_we[1] == 2'b00) |=>
      data[1] == $past(count[1]))
    else $error("capture did not store the counter");

  unused_halt_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (t0_mode_r[2] && t0_mode_r[1:0] != 2'h0 && cnt_we[0] == 2'b00) |=>
      count[0] == $past(count[0]))
    else $error("unused mode code let timer 0 move");

  freq_run_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (t0_mode_r == 3'h4) |-> (ctl[0].run && !ctl[0].capture_sel))
    else $error("measurement code does not run timer 0");

  ext_clk_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (t0_clk_r == 2'h2 && PORT_B_LINE_TWO_I && !$past(PORT_B_LINE_TWO_I)) |-> tick[0])
    else $error("port pin edge did not clock timer 0");

  chain_tick_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (t1_clk_r == 2'h3 && t1_mode_r == 2'h0 && ovf[0]) |-> (tick[1] && ctl[1].run))
    else $error("timer 0 overflow did not clock timer 1");

  high_tick_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (t1_clk_r == 2'h1 && high_rise) |-> tick[1])
    else $error("high-speed edge did not clock timer 1");

  read_nib_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (setup_ph && hit(PADDR_I, `TQT_IDX_T0_CNT_HI)) |=> PRDATA_O == {28'h0, $past(count[0][7:4])})
    else $error("counter upper nibble read wrong");

  // The timebase edge clocks timer 0 when selected.
  low_tick_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (t0_clk_r == 2'h0 && low_rise) |-> tick[0])
    else $error("timebase edge did not clock timer 0");

  // The unused clock code gives timer 0 no pulses at all.
  clk_off_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (t0_clk_r == 2'h3) |-> !tick[0])
    else $error("unused clock code clocked timer 0");

  // A mode write lands in the field on the completing edge.
  mode_write_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (wr_en && hit(PADDR_I, `TQT_IDX_T0_MODE)) |=> t0_mode_r == $past(wnib[2:0]))
    else $error("mode write did not land");

  // Capture stopped keeps timer 1 still.
  t1_stop_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (t1_mode_r == 2'h2 && cnt_we[1] == 2'b00) |=> count[1] == $past(count[1]))
    else $error("stopped timer 1 moved");

  // Chained step: a timer 0 wrap while timer 1 sits below its top.
  sequence chain_step_s;
    t1_chained && ovf[0] && cnt_we[1] == 2'b00 && count[1] != 8'hff;
  endsequence

  chain_count_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    chain_step_s |=> count[1] == $past(count[1]) + 8'h01)
    else $error("chained timer 1 did not step");

endmodule : tqt_timer

`default_nettype wire

/* File: tqt_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Stands in for the outside world: timer clock pins and capture pins.
module tqt_pin_model (
  input wire logic clk_i, // System clock.
  output logic [3:0] tclk_o, // Timer 1 external, port b line two, high, low.
  output logic [1:0] cap_o // Capture pins of timers 1 and 0.
);
  // Pins start low so that the first pulse gives a clean rising edge.
  initial begin
    tclk_o = 4'h0;
    cap_o = 2'h0;
  end

  // Oscillator already settled.
  // The model starts with its oscillator settled, so no wait is simulated.
  // Pulses stay two cycles high and three low between pulses, since the pins are sampled.
  task automatic pulse(input logic [3:0] m, input int n);
    repeat (n) begin
      @(posedge clk_i);
      tclk_o <= m;
      repeat (2) @(posedge clk_i);
      tclk_o <= 4'h0;
      repeat (2) @(posedge clk_i);
    end
  endtask : pulse

  // Any level change of a capture pin is one capture event.
  task automatic flip(input int k);
    @(posedge clk_i);
    cap_o[k] <= ~cap_o[k];
    repeat (3) @(posedge clk_i);
  endtask : flip
endmodule : tqt_pin_model

`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tqt_defs.svh"

module tb;
  logic clk = 1'b0; // System clock.
  logic rst_n = 1'b0; // Reset, active low.
  logic psel = 1'b0; // Bus select.
  logic penable = 1'b0; // Bus access phase.
  logic pwrite = 1'b0; // Bus direction.
  logic [11:0] paddr = 12'h000; // Bus byte address.
  logic [31:0] pwdata = 32'h0; // Bus write data.
  logic [31:0] prdata; // Bus read data.
  logic pready; // Bus ready.
  logic pslverr; // Bus error.
  logic [3:0] tclk; // Timer clock pins.
  logic [1:0] cap; // Capture pins.
  int num_errors = 0; // Mismatches seen.
  int cmp_count = 0; // Comparisons made.
  int cyc = 0; // Cycles run, for the hang guard.
  logic [31:0] seed = 32'h34; // Random state, fixed start of 52.
  logic [3:0] rd; // Last nibble read.
  logic [27:0] rd_hi; // Upper read bits, always zero.
  logic err; // Last error flag.
  logic [7:0] v; // Value written.
  logic [7:0] w; // Value read back.
  logic [9:0] cl [4] = '{10'h06c, 10'h06e, 10'h07a, 10'h07c}; // Counter indices.
  logic [7:0] msk [4] = '{8'h07, 8'h03, 8'h03, 8'h03}; // Control widths.

  always #20 clk = ~clk;

  tqt_timer u_tqt_timer (.CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PSTRB_I(4'hf), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .LOW_SPEED_TIMEBASE_CLOCK_I(tclk[0]), .HIGH_SPEED_CLOCK_I(tclk[1]),
    .PORT_B_LINE_TWO_I(tclk[2]), .T1_EXT_CLOCK_I(tclk[3]),
    .T0_CAPTURE_I(cap[0]), .T1_CAPTURE_I(cap[1]));
  tqt_pin_model u_tqt_pin_model (.clk_i(clk), .tclk_o(tclk), .cap_o(cap));

  // Xorshift keeps the random values repeatable.
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd

  // Gain of timer 0 after one low, two high and four external pulses.
  function automatic logic [7:0] gain(input logic [2:0] m, input logic [1:0] c);
    if (!(m == 3'h1 || m == 3'h3 || m == 3'h4)) return 8'h00;
    return (c == 2'h3) ? 8'h00 : 8'h01 << c;
  endfunction : gain

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One bus transfer; the wait for ready is bounded, not assumed.
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [3:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= {28'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED at %0t: no ready from the slave", $time);
    end
    rd = prdata[3:0];
    rd_hi = prdata[31:4];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd8(input logic [9:0] lo, output logic [7:0] val);
    apb(1'b0, lo, 4'h0);
    val[3:0] = rd;
    apb(1'b0, lo + 10'h1, 4'h0);
    val[7:4] = rd;
  endtask : rd8

  task automatic wr8(input logic [9:0] lo, input logic [7:0] val);
    apb(1'b1, lo, val[3:0]);
    apb(1'b1, lo + 10'h1, val[7:4]);
  endtask : wr8

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  // A hang ends the run as a failure instead of running forever.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      $display("CHECK FAILED at %0t: run timed out", $time);
      print_verdict();
    end
  end

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    // Every place reads zero after reset; the two status holes are unmapped.
    for (int i = 'h68; i <= 'h7d; i++) begin
      apb(1'b0, 10'(i), 4'h0);
      check({4'h0, rd}, 8'h00);
      check({7'h0, err}, {7'h0, (i == 'h74 || i == 'h75)});
      check({7'h0, |rd_hi}, 8'h00);
    end
    $display("reset values done");
    for (int k = 0; k < 4; k++) begin
      v = rnd();
      wr8(cl[k], v);
      rd8(cl[k], w);
      check(w, v);
      rd8(cl[k] - 10'h4, w);
      check(w, v);
      wr8(cl[k] - 10'h4, ~v);
      rd8(cl[k], w);
      check(w, v);
      apb(1'b1, 10'h070 + 10'(k), 4'hf);
      apb(1'b0, 10'h070 + 10'(k), 4'h0);
      check({4'h0, rd}, msk[k]);
      apb(1'b1, 10'h070 + 10'(k), 4'h0);
    end
    $display("register access done");
    // Every mode code against every clock source, unused codes included.
    for (int m = 0; m < 8; m++) begin
      for (int c = 0; c < 4; c++) begin
        v = rnd() & 8'h7f;
        apb(1'b1, `TQT_IDX_T0_MODE, 4'(m));
        apb(1'b1, `TQT_IDX_T0_CLK, 4'(c));
        wr8(`TQT_IDX_T0_CNT_LO, v);
        u_tqt_pin_model.pulse(4'h1, 1);
        u_tqt_pin_model.pulse(4'h2, 2);
        u_tqt_pin_model.pulse(4'h4, 4);
        rd8(`TQT_IDX_T0_CNT_LO, w);
        check(w, v + gain(3'(m), 2'(c)));
      end
    end
    $display("mode and clock select done");
    apb(1'b1, `TQT_IDX_T0_MODE, 4'h1);
    apb(1'b1, `TQT_IDX_T0_CLK, 4'h2);
    wr8(`TQT_IDX_T0_CNT_LO, 8'hff);
    wr8(`TQT_IDX_T0_DAT_LO, 8'h05);
    u_tqt_pin_model.pulse(4'h4, 1);
    rd8(`TQT_IDX_T0_CNT_LO, w);
    check(w, 8'h05);
    // Chained mode: timer 1 counts timer 0 overflows.
    wr8(`TQT_IDX_T0_CNT_LO, 8'hfe);
    wr8(`TQT_IDX_T1_CNT_LO, 8'h00);
    apb(1'b1, `TQT_IDX_T1_CLK, 4'h3);
    u_tqt_pin_model.pulse(4'h4, 2);
    rd8(`TQT_IDX_T1_CNT_LO, w);
    check(w, 8'h01);
    rd8(`TQT_IDX_T0_CNT_LO, w);
    check(w, 8'hfe);
    $display("reload and chain done");
    apb(1'b1, `TQT_IDX_T1_MODE, 4'h1);
    apb(1'b1, `TQT_IDX_T1_CLK, 4'h1);
    wr8(`TQT_IDX_T1_CNT_LO, 8'h10);
    u_tqt_pin_model.pulse(4'h2, 3);
    apb(1'b1, `TQT_IDX_T1_CLK, 4'h2);
    u_tqt_pin_model.pulse(4'h8, 2);
    rd8(`TQT_IDX_T1_CNT_LO, w);
    check(w, 8'h15);
    // Capture of both timers after a few counts.
    apb(1'b1, `TQT_IDX_T0_MODE, 4'h3);
    apb(1'b1, `TQT_IDX_T1_MODE, 4'h3);
    wr8(`TQT_IDX_T0_CNT_LO, 8'h30);
    wr8(`TQT_IDX_T1_CNT_LO, 8'h40);
    u_tqt_pin_model.pulse(4'hc, 3);
    u_tqt_pin_model.flip(0);
    u_tqt_pin_model.flip(1);
    rd8(`TQT_IDX_T0_DAT_LO, w);
    check(w, 8'h33);
    rd8(`TQT_IDX_T1_DAT_LO, w);
    check(w, 8'h43);
    // Capture stopped: timer 1 neither counts nor captures, then the timebase runs it.
    apb(1'b1, `TQT_IDX_T1_MODE, 4'h2);
    wr8(`TQT_IDX_T1_DAT_LO, 8'h5a);
    u_tqt_pin_model.pulse(4'h8, 2);
    u_tqt_pin_model.flip(1);
    rd8(`TQT_IDX_T1_DAT_LO, w);
    check(w, 8'h5a);
    apb(1'b1, `TQT_IDX_T1_CLK, 4'h0);
    apb(1'b1, `TQT_IDX_T1_MODE, 4'h1);
    u_tqt_pin_model.pulse(4'h1, 1);
    rd8(`TQT_IDX_T1_CNT_LO, w);
    check(w, 8'h44);
    $display("timer 1 clocks and capture done");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd8(`TQT_IDX_T1_CNT_LO, w);
    check(w, 8'h00);
    apb(1'b0, `TQT_IDX_T1_CLK, 4'h0);
    check({4'h0, rd}, 8'h00);
    $display("second reset done");
    print_verdict();
  end
endmodule : tb

`default_nettype wire
